// file: logic/subtract_store_datapath.sv
// Subtract and integer store execution datapath with register slave
// Overview of operation
// (RULE1) Dual stores to one address leave the second store's value.
// (RULE2) Dual store writes both words in one instruction, flags untouched.
// (RULE3) Borrow subtract: dst minus src minus carry, signed, registers 0-27.
// (RULE4) Subtracts update flags only for destination registers 0-7.
// (RULE5) Integer subtract: carry on borrow, N, Z from result, underflow cleared.
// (RULE6) Integer overflow sets V and sticky latched overflow; else V cleared.
// (RULE7) Only borrow subtracts obey saturate mode; others ignore it.
// (RULE8) Three-operand borrow subtract: src1 minus src2 minus carry.
// (RULE9) Two-operand source codes: register, direct, indirect, immediate.
// (RULE10) Conditional subtract writes shifted difference plus one or shifted dst.
// (RULE11) Conditional subtract is unsigned and changes no flag.
// (RULE12) Float subtract: dst minus src, registers 0-7, carry untouched.
// (RULE13) Float underflow/overflow set sticky latched flags.
// (RULE14) Float subtract sets underflow, V from events and N, Z from result.
// (RULE15) Three-operand float subtract: src1 minus src2 into register 0-7.
// (RULE16) Interlocked store writes memory and signals interlock end on pins.
// (RULE17) Sources read at cycle start, results written at cycle end.
// (RULE18) Every instruction executes in one clock cycle.
// (RULE19) Saturate mode clamps overflowing integer results to the limit.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module subtract_store_datapath
  import subtract_store_pkg::*;
(
  input  wire logic        clk,             // Core clock
  input  wire logic        sys_rst,         // Asynchronous reset
  input  wire logic        issue_valid,     // Instruction offered
  input  wire insn_type    issue_insn,      // Decoded instruction
  output logic             issue_ready,     // Datapath accepts
  output logic             exec_done,       // One-cycle completion pulse
  output mem_wr_type       store_a,         // First store port
  output mem_wr_type       store_b,         // Second store port
  output logic             lock_req_o,      // Interlock request pin value
  output logic             lock_req_oe,     // Interlock request pin enable
  output logic             irq,             // Level interrupt
  input  wire logic [11:0] s_axi_awaddr,    // AXI write address
  input  wire logic        s_axi_awvalid,   // AXI write address valid
  output logic             s_axi_awready,   // AXI write address ready
  input  wire logic [31:0] s_axi_wdata,     // AXI write data
  input  wire logic [3:0]  s_axi_wstrb,     // AXI byte strobes
  input  wire logic        s_axi_wvalid,    // AXI write data valid
  output logic             s_axi_wready,    // AXI write data ready
  output logic [1:0]       s_axi_bresp,     // AXI write response
  output logic             s_axi_bvalid,    // AXI write response valid
  input  wire logic        s_axi_bready,    // AXI write response ready
  input  wire logic [11:0] s_axi_araddr,    // AXI read address
  input  wire logic        s_axi_arvalid,   // AXI read address valid
  output logic             s_axi_arready,   // AXI read address ready
  output logic [31:0]      s_axi_rdata,     // AXI read data
  output logic [1:0]       s_axi_rresp,     // AXI read response
  output logic             s_axi_rvalid,    // AXI read data valid
  input  wire logic        s_axi_rready     // AXI read data ready
);

  logic [31:0]       rf_q [REG_COUNT];
  logic [FLAG_W-1:0] flags_q;
  logic              sat_mode_q;
  logic [EV_W-1:0]   int_st_q;
  logic [EV_W-1:0]   int_msk_q;
  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;
  logic              ready_q, done_q, lreq_q, lreq_oe_q, irq_q;
  mem_wr_type        st_a_q, st_b_q;

  // Float in 32-bit form: signed exponent [31:24], two's complement
  // mantissa sign [23], fraction [22:0]; exponent 80h means zero.
  // Truncates rather than rounds to keep the path to one cycle.
  function automatic logic [33:0] float_sub(input logic [31:0] a,
                                            input logic [31:0] b);
    logic signed [7:0]  ea, eb, eh;
    logic signed [26:0] ma, mb, sum;
    logic [7:0]         dif;
    logic [4:0]         n;
    logic               stop;
    logic signed [9:0]  er;
    logic [26:0]        sh;
    ea = a[31:24];
    eb = b[31:24];
    ma = (a[31:24] == FLT_ZERO_EXP) ? 27'sd0
         : 27'(signed'({a[23], ~a[23], a[22:0]}));
    mb = (b[31:24] == FLT_ZERO_EXP) ? 27'sd0
         : 27'(signed'({b[23], ~b[23], b[22:0]}));
    if (ea >= eb) begin
      eh  = ea;
      dif = 8'(ea - eb);
      mb  = (dif > 8'd26) ? (mb >>> 26) : (mb >>> dif);
    end else begin
      eh  = eb;
      dif = 8'(eb - ea);
      ma  = (dif > 8'd26) ? (ma >>> 26) : (ma >>> dif);
    end
    sum  = ma - mb;
    n    = 5'd0;
    stop = 1'b0;
    for (int i = 25; i >= 0; i--) begin
      if (!stop && sum[i] == sum[26]) n = n + 5'd1;
      else stop = 1'b1;
    end
    sh = 27'(sum <<< n);
    er = 10'(eh) + 10'sd2 - 10'(signed'({5'd0, n}));
    // Result, overflow in bit 32, underflow in bit 33
    if (sum == 27'sd0) float_sub = {2'b00, FLT_ZERO};
    else if (er > FLT_EXP_MAX)
      float_sub = {2'b01, sh[26] ? FLT_MAX_NEG : FLT_MAX_POS};
    else if (er < FLT_EXP_MIN) float_sub = {2'b10, FLT_ZERO};
    else float_sub = {2'b00, er[7:0], sh[26], sh[24:2]};
  endfunction : float_sub

  // Execute stage, all operands from the pre-instruction state
  insn_type          ins;
  logic [31:0]       op1, op2, res;
  logic [32:0]       diff;
  logic [33:0]       fres;
  logic              wr_en, fl_we, ovf;
  logic [FLAG_W-1:0] fl_new;
  logic [EV_W-1:0]   ev;

  always_comb begin
    ins    = issue_insn;
    op1    = rf_q[ins.dst];
    op2    = rf_q[ins.src_b];
    res    = 32'h00000000;
    diff   = 33'h000000000;
    fres   = 34'h000000000;
    wr_en  = 1'b0;
    fl_we  = 1'b0;
    ovf    = 1'b0;
    fl_new = flags_q;
    ev     = '0;
    unique case (ins.mode_b)                               // see (RULE9)
      2'b00:   op2 = rf_q[ins.src_b];
      2'b01:   op2 = ins.mem_b;
      2'b10:   op2 = ins.mem_b;
      2'b11:   op2 = ins.imm;
    endcase
    if (ins.op == OP_SUB_BORROW3 || ins.op == OP_FLOAT_SUB3) begin
      op1 = ins.mode_a[0] ? ins.mem_a : rf_q[ins.src_a];     // see (RULE8)
      op2 = ins.mode_b[1] ? ins.mem_b : rf_q[ins.src_b];     // see (RULE8)
    end
    unique case (ins.op)
      OP_SUB_BORROW, OP_SUB_BORROW3: begin
        diff  = {1'b0, op1} - {1'b0, op2} - 33'(flags_q[C_BIT]); // see (RULE3)
        ovf   = (op1[31] != op2[31]) && (diff[31] != op1[31]);
        res   = diff[31:0];
        if (ovf && sat_mode_q)                          // see (RULE7) (RULE19)
          res = op1[31] ? INT_MAX_NEG : INT_MAX_POS;
        wr_en = 1'b1;
        fl_we = ins.dst <= 5'(EXT_REG_LAST);                  // see (RULE4)
        fl_new[C_BIT]  = diff[32];                            // see (RULE5)
        fl_new[N_BIT]  = res[31];
        fl_new[Z_BIT]  = res == 32'h00000000;
        fl_new[UNF_BIT] = 1'b0;
        fl_new[V_BIT]  = ovf;                                 // see (RULE6)
        fl_new[LOVF_BIT] = flags_q[LOVF_BIT] | ovf;
        ev[EV_INT_OVF] = ovf && fl_we;
      end
      OP_COND_SUB: begin
        diff  = {1'b0, op1} - {1'b0, op2};          // see (RULE10) (RULE11)
        res   = diff[32] ? {op1[30:0], 1'b0} : {diff[30:0], 1'b1};
        wr_en = 1'b1;
      end
      OP_FLOAT_SUB, OP_FLOAT_SUB3: begin
        fres  = float_sub(op1, op2);                  // see (RULE12) (RULE15)
        res   = fres[31:0];
        wr_en = ins.dst <= 5'(EXT_REG_LAST);
        fl_we = wr_en;                                        // see (RULE4)
        fl_new[UNF_BIT]  = fres[33];                          // see (RULE14)
        fl_new[V_BIT]   = fres[32];
        fl_new[N_BIT]   = res[23] && !fres[33];
        fl_new[Z_BIT]   = res[31:24] == FLT_ZERO_EXP;
        fl_new[LUNF_BIT] = flags_q[LUNF_BIT] | fres[33];      // see (RULE13)
        fl_new[LOVF_BIT] = flags_q[LOVF_BIT] | fres[32];
        ev[EV_FLT_OVF]  = fres[32] && fl_we;
        ev[EV_FLT_UNF]  = fres[33] && fl_we;
      end
      OP_LOCKED_STORE: ev[EV_LOCK_END] = 1'b1;
      default: ;
    endcase
  end

  logic go;
  assign go = issue_valid && ready_q;

  // Register file: execute writeback wins over a bus write to one entry
  logic        bus_wr;
  logic [11:0] bus_addr;
  assign bus_wr   = awready_q && wready_q && s_axi_awvalid && s_axi_wvalid;
  assign bus_addr = s_axi_awaddr;

  generate
    for (genvar r = 0; r < REG_COUNT; r++) begin : g_rf
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          rf_q[r] <= 32'h00000000;
        end else if (go && wr_en && ins.dst == 5'(r)) begin  // see (RULE17)
          rf_q[r] <= res;
        end else if (bus_wr && bus_addr == RF_BASE_ADDR + 12'(4 * r)) begin
          rf_q[r] <= s_axi_wdata;
        end
      end
    end
  endgenerate

  // Condition flags; hardware update has priority over software
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= FLAGS_RESET;
    end else if (go && fl_we) begin                           // see (RULE4)
      flags_q <= fl_new;
    end else if (bus_wr && bus_addr == FLAGS_ADDR) begin
      flags_q <= s_axi_wdata[FLAG_W-1:0];
    end
  end

  // Stores: operand values come from the registers before writeback
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_a_q <= '0;
      st_b_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q    <= go;                                       // see (RULE18)
      st_a_q.en <= 1'b0;
      st_b_q.en <= 1'b0;
      st_a_q.addr <= ins.addr_a;
      st_a_q.data <= rf_q[ins.src_a];                        // see (RULE17)
      st_b_q.addr <= ins.addr_b;
      st_b_q.data <= rf_q[ins.src_b];
      if (go) begin
        unique case (ins.op)
          OP_INT_STORE, OP_LOCKED_STORE: st_a_q.en <= 1'b1;  // see (RULE16)
          OP_DUAL_STORE: begin                                // see (RULE2)
            st_b_q.en <= 1'b1;
            st_a_q.en <= ins.addr_a != ins.addr_b;            // see (RULE1)
          end
          default: ;
        endcase
      end
    end
  end

  // Interlock pin: high marks the end of an interlocked operation
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lreq_q    <= 1'b1;
      lreq_oe_q <= 1'b0;
      ready_q   <= 1'b0;
    end else begin
      ready_q <= 1'b1;
      if (go && ins.op == OP_LOCKED_STORE) begin              // see (RULE16)
        lreq_q    <= 1'b1;
        lreq_oe_q <= 1'b1;
      end
    end
  end

  // Control, mask and sticky interrupt status; a new event beats clearing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sat_mode_q <= 1'b0;
      int_msk_q  <= '0;
      int_st_q   <= '0;
      irq_q      <= 1'b0;
    end else begin
      if (bus_wr && bus_addr == CTRL_ADDR) sat_mode_q <= s_axi_wdata[SAT_BIT];
      if (bus_wr && bus_addr == INT_MSK_ADDR)
        int_msk_q <= s_axi_wdata[EV_W-1:0];
      if (bus_wr && bus_addr == INT_ST_ADDR)
        int_st_q <= (int_st_q & ~s_axi_wdata[EV_W-1:0]) | (go ? ev : '0);
      else if (go)
        int_st_q <= int_st_q | ev;
      irq_q <= |(int_st_q & int_msk_q);
    end
  end

  // Write channel: both address and data are taken in the same cycle
  logic wmapped;
  assign wmapped = (bus_addr[1:0] == 2'b00) &&
                   (bus_addr <= INT_MSK_ADDR ||
                    (bus_addr >= RF_BASE_ADDR && bus_addr <= RF_END_ADDR));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      if (!awready_q && !bvalid_q && s_axi_awvalid && s_axi_wvalid) begin
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
      if (bus_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wmapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_val = 32'h00000000;
    rd_ok  = s_axi_araddr[1:0] == 2'b00;
    if (s_axi_araddr == CTRL_ADDR) rd_val = 32'(sat_mode_q);
    else if (s_axi_araddr == FLAGS_ADDR) rd_val = 32'(flags_q);
    else if (s_axi_araddr == INT_ST_ADDR) rd_val = 32'(int_st_q);
    else if (s_axi_araddr == INT_MSK_ADDR) rd_val = 32'(int_msk_q);
    else if (s_axi_araddr >= RF_BASE_ADDR && s_axi_araddr <= RF_END_ADDR)
      rd_val = rf_q[5'((s_axi_araddr - RF_BASE_ADDR) >> 2)];
    else rd_ok = 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= !arready_q && !rvalid_q && s_axi_arvalid;
      if (arready_q && s_axi_arvalid) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_ok ? rd_val : 32'h00000000;
        rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign issue_ready   = ready_q;
  assign exec_done     = done_q;
  assign store_a       = st_a_q;
  assign store_b       = st_b_q;
  assign lock_req_o    = lreq_q;
  assign lock_req_oe   = lreq_oe_q;
  assign irq           = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
endmodule : subtract_store_datapath

// file: logic/subtract_store_pkg.sv
// Constants and carrier types for the subtract and store datapath
package subtract_store_pkg;
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned REG_COUNT    = 28;
  localparam int unsigned EXT_REG_LAST = 7;
  // Register map, byte addresses
  localparam logic [11:0] CTRL_ADDR    = 12'h000;
  localparam logic [11:0] FLAGS_ADDR   = 12'h004;
  localparam logic [11:0] INT_ST_ADDR  = 12'h008;
  localparam logic [11:0] INT_MSK_ADDR = 12'h00C;
  localparam logic [11:0] RF_BASE_ADDR = 12'h100;
  localparam logic [11:0] RF_END_ADDR  = 12'h16C;
  // Control register fields
  localparam int unsigned SAT_BIT      = 0;
  // Condition flag positions inside the flags register
  localparam int unsigned C_BIT   = 0;
  localparam int unsigned V_BIT   = 1;
  localparam int unsigned Z_BIT   = 2;
  localparam int unsigned N_BIT   = 3;
  localparam int unsigned UNF_BIT  = 4;
  localparam int unsigned LOVF_BIT = 5;
  localparam int unsigned LUNF_BIT = 6;
  localparam int unsigned FLAG_W  = 7;
  localparam logic [6:0]  FLAGS_RESET = 7'h00;
  // Interrupt event positions
  localparam int unsigned EV_INT_OVF  = 0;
  localparam int unsigned EV_FLT_OVF  = 1;
  localparam int unsigned EV_FLT_UNF  = 2;
  localparam int unsigned EV_LOCK_END = 3;
  localparam int unsigned EV_W        = 4;
  // Bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Integer and float limits
  localparam logic [31:0] INT_MAX_POS = 32'h7FFFFFFF;
  localparam logic [31:0] INT_MAX_NEG = 32'h80000000;
  localparam logic [31:0] FLT_ZERO    = 32'h80000000;
  localparam logic [31:0] FLT_MAX_POS = 32'h7F7FFFFF;
  localparam logic [31:0] FLT_MAX_NEG = 32'h7F800000;
  localparam logic [7:0]  FLT_ZERO_EXP = 8'h80;
  localparam logic signed [9:0] FLT_EXP_MAX = 10'sd127;
  localparam logic signed [9:0] FLT_EXP_MIN = -10'sd127;

  typedef enum logic [2:0] {
    OP_SUB_BORROW, OP_SUB_BORROW3, OP_COND_SUB, OP_FLOAT_SUB,
    OP_FLOAT_SUB3, OP_INT_STORE, OP_DUAL_STORE, OP_LOCKED_STORE
  } op_type;

  // One decoded instruction with its memory operands already fetched
  typedef struct packed {
    op_type      op;
    logic [4:0]  dst;     // Destination register
    logic [4:0]  src_a;   // First source / first store register
    logic [4:0]  src_b;   // Second source / second store register
    logic [1:0]  mode_a;  // Mode code of first source
    logic [1:0]  mode_b;  // Mode code of second source
    logic [31:0] mem_a;   // Memory operand for first source
    logic [31:0] mem_b;   // Memory operand for second source
    logic [31:0] imm;     // Immediate, already extended
    logic [31:0] addr_a;  // Store address for src_a
    logic [31:0] addr_b;  // Store address for src_b
  } insn_type;

  typedef struct packed {
    logic        en;
    logic [31:0] addr;
    logic [31:0] data;
  } mem_wr_type;
endpackage : subtract_store_pkg

// file: tb/subtract_store_monitor.sv
// Concurrent checks on the instruction and store ports of the datapath
`timescale 1ns/10ps
module subtract_store_monitor
  import subtract_store_pkg::*;
(
  input wire logic       clk,          // Core clock
  input wire logic       sys_rst,      // Asynchronous reset
  input wire logic       issue_valid,  // Instruction offered
  input wire insn_type   issue_insn,   // Decoded instruction
  input wire logic       issue_ready,  // Datapath accepts
  input wire logic       exec_done,    // Completion pulse
  input wire mem_wr_type store_a,      // First store port
  input wire mem_wr_type store_b,      // Second store port
  input wire logic       lock_req_o,   // Interlock request level
  input wire logic       lock_req_oe   // Interlock request enable
);
  logic tk;
  logic same;

  assign tk = issue_valid && issue_ready;
  assign same = issue_insn.addr_a == issue_insn.addr_b;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_issue_done: assert property (tk |=> exec_done)
    else $error("accepted instruction gave no completion");
  a_done_cause: assert property (exec_done |-> $past(tk))
    else $error("completion without an accepted instruction");
  a_dual_both: assert property (
    tk && issue_insn.op == OP_DUAL_STORE && !same
    |=> store_a.en && store_b.en && store_a.addr == $past(issue_insn.addr_a))
    else $error("dual store did not write both words");
  a_dual_same: assert property (
    tk && issue_insn.op == OP_DUAL_STORE && same
    |=> !store_a.en && store_b.en && store_b.addr == $past(issue_insn.addr_b))
    else $error("same-address dual store kept the wrong word");
  a_lock_pins: assert property (
    tk && issue_insn.op == OP_LOCKED_STORE
    |=> store_a.en && lock_req_oe && lock_req_o)
    else $error("interlocked store missed its write or pins");
  a_sub_no_store: assert property (
    tk && issue_insn.op inside {[OP_SUB_BORROW:OP_FLOAT_SUB3]}
    |=> !store_a.en && !store_b.en)
    else $error("subtract drove a store port");
  a_store_with_done: assert property (
    (store_a.en || store_b.en) |-> exec_done)
    else $error("store outside a completion cycle");
  a_oe_sticky: assert property ($rose(lock_req_oe) |=> lock_req_oe[*3])
    else $error("interlock enable dropped");

  c_locked: cover property (tk && issue_insn.op == OP_LOCKED_STORE);
  c_same: cover property (store_b.en && !store_a.en);
  c_three: cover property (tk && issue_insn.op == OP_SUB_BORROW3);
endmodule : subtract_store_monitor

// file: tb/tb_subtract_store_datapath.sv
// Self-checking bench driving the datapath and its register bus
`timescale 1ns/10ps
module tb_subtract_store_datapath
  import subtract_store_pkg::*;
;
  logic        clk, sys_rst, issue_valid, issue_ready, exec_done;
  logic        lock_req_o, lock_req_oe, irq;
  insn_type    issue_insn;
  mem_wr_type  store_a, store_b;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdata_s;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bresp_s, rresp_s;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          err_count, checks_done;
  insn_type    ins;

  subtract_store_datapath dut_u (.clk, .sys_rst, .issue_valid, .issue_insn,
    .issue_ready, .exec_done, .store_a, .store_b, .lock_req_o, .lock_req_oe,
    .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // Address and data are taken on the same edge; each valid is still dropped on its own ready
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    bresp_s = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdata_s = s_axi_rdata;
    rresp_s = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(rdata_s, e);
  endtask : rchk

  // Outputs of the instruction are looked at in their single valid cycle
  task automatic issue(input insn_type i);
    @(posedge clk);
    issue_valid <= 1'b1;
    issue_insn <= i;
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
  endtask : issue

  function automatic logic [11:0] ra(input int n);
    return RF_BASE_ADDR + 12'(4 * n);
  endfunction : ra

  function automatic insn_type mk(input op_type op, input logic [4:0] d,
    input logic [4:0] s, input logic [1:0] m, input logic [31:0] v);
    mk = '0;
    mk.op = op;
    mk.dst = d;
    mk.src_b = s;
    mk.mode_b = m;
    mk.mem_b = v;
    mk.imm = v;
  endfunction : mk

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    test_done();
  end

  initial begin
    {sys_rst, issue_valid, issue_insn} = '0;
    sys_rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(issue_ready, 1'b1);
    chk({lock_req_o, lock_req_oe}, 2'h2);
    rchk(FLAGS_ADDR, 32'h0);
    rd(12'h200);
    chk(rresp_s, RESP_SLVERR);
    wr(12'h200, 32'h0);
    chk(bresp_s, RESP_SLVERR);
    $display("Test reset and map done");
    wr(ra(5), 32'hFA);
    wr(FLAGS_ADDR, 32'h1);
    issue(mk(OP_SUB_BORROW, 5'd5, 5'd0, 2'h1, 32'hC7));
    chk(exec_done, 1'b1);
    rchk(ra(5), 32'h32);
    rchk(FLAGS_ADDR, 32'h0);
    wr(FLAGS_ADDR, 32'h1);
    ins = mk(OP_SUB_BORROW3, 5'd0, 5'd5, 2'h0, 32'h0);
    ins.mode_a = 2'h1;
    ins.mem_a = 32'hFA;
    issue(ins);
    rchk(ra(0), 32'hC7);
    ins.mode_a = 2'h2;
    ins.mode_b = 2'h3;
    ins.mem_b = 32'h47;
    issue(ins);
    rchk(ra(0), 32'h80);
    wr(ra(9), 32'h10);
    for (int m = 0; m < 4; m++) begin
      wr(ra(1), 32'h100);
      ins = mk(OP_SUB_BORROW, 5'd1, 5'd9, 2'(m), 32'h3);
      ins.imm = 32'h5;
      issue(ins);
      rchk(ra(1), m == 0 ? 32'hF0 : m == 3 ? 32'hFB : 32'hFD);
    end
    $display("Test borrow subtract done");
    wr(CTRL_ADDR, 32'h1);
    wr(INT_MSK_ADDR, 32'h1);
    wr(FLAGS_ADDR, 32'h0);
    wr(ra(1), INT_MAX_NEG);
    issue(mk(OP_SUB_BORROW, 5'd1, 5'd0, 2'h3, 32'h1));
    rchk(ra(1), INT_MAX_NEG);
    rchk(FLAGS_ADDR, 32'h2A);
    chk(irq, 1'b1);
    wr(INT_ST_ADDR, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk(irq, 1'b0);
    wr(CTRL_ADDR, 32'h0);
    wr(ra(1), INT_MAX_NEG);
    issue(mk(OP_SUB_BORROW, 5'd1, 5'd0, 2'h3, 32'h1));
    rchk(ra(1), INT_MAX_POS);
    rchk(FLAGS_ADDR, 32'h22);
    wr(INT_MSK_ADDR, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk(irq, 1'b0);
    $display("Test overflow and interrupt done");
    issue(mk(OP_SUB_BORROW, 5'd2, 5'd0, 2'h3, 32'h1));
    rchk(ra(2), 32'hFFFFFFFF);
    rchk(FLAGS_ADDR, 32'h29);
    issue(mk(OP_SUB_BORROW, 5'd27, 5'd0, 2'h3, 32'h1));
    rchk(ra(27), 32'hFFFFFFFE);
    rchk(FLAGS_ADDR, 32'h29);
    $display("Test flag scope done");
    wr(ra(1), 32'h4F6);
    issue(mk(OP_COND_SUB, 5'd1, 5'd0, 2'h1, 32'h492));
    rchk(ra(1), 32'hC9);
    wr(ra(1), 32'h7D0);
    issue(mk(OP_COND_SUB, 5'd1, 5'd0, 2'h3, 32'hBB8));
    rchk(ra(1), 32'hFA0);
    rchk(FLAGS_ADDR, 32'h29);
    $display("Test conditional subtract done");
    wr(FLAGS_ADDR, 32'h21);
    wr(ra(5), 32'h0733C000);
    issue(mk(OP_FLOAT_SUB, 5'd5, 5'd0, 2'h1, 32'h070C8000));
    rchk(ra(5), 32'h051D0000);
    rchk(FLAGS_ADDR, 32'h21);
    wr(ra(7), 32'h057B4000);
    wr(ra(0), 32'h034C2000);
    issue(mk(OP_FLOAT_SUB3, 5'd6, 5'd7, 2'h0, 32'h0));
    rchk(ra(6), 32'h05B7C800);
    rchk(FLAGS_ADDR, 32'h29);
    wr(ra(4), 32'h7F000000);
    issue(mk(OP_FLOAT_SUB, 5'd4, 5'd0, 2'h3, 32'h7F800000));
    rchk(ra(4), FLT_MAX_POS);
    rchk(FLAGS_ADDR, 32'h23);
    wr(ra(4), 32'h81400000);
    issue(mk(OP_FLOAT_SUB, 5'd4, 5'd0, 2'h3, 32'h81000000));
    rchk(ra(4), FLT_ZERO);
    rchk(FLAGS_ADDR, 32'h75);
    rchk(INT_ST_ADDR, 32'h7);
    wr(INT_ST_ADDR, 32'h6);
    $display("Test float subtract done");
    wr(ra(2), 32'hDC);
    wr(ra(3), 32'h35);
    ins = mk(OP_DUAL_STORE, 5'd0, 5'd3, 2'h0, 32'h0);
    ins.src_a = 5'd2;
    ins.addr_a = 32'h809838;
    ins.addr_b = 32'h8098D3;
    issue(ins);
    chk({store_a.en, store_b.en}, 2'h3);
    chk(store_a.data, 32'hDC);
    chk(store_b.data, 32'h35);
    ins.addr_b = ins.addr_a;
    issue(ins);
    chk({store_a.en, store_b.en}, 2'h1);
    chk(store_b.data, 32'h35);
    rchk(FLAGS_ADDR, 32'h75);
    $display("Test dual store done");
    ins.op = OP_LOCKED_STORE;
    ins.addr_a = 32'h8098AE;
    issue(ins);
    chk({store_a.en, lock_req_o, lock_req_oe}, 3'h7);
    chk(store_a.data, 32'hDC);
    rchk(INT_ST_ADDR, 32'h9);
    wr(INT_MSK_ADDR, 32'h8);
    repeat (2) @(posedge clk);
    #1;
    chk(irq, 1'b1);
    $display("Test interlocked store done");
    test_done();
  end
endmodule : tb_subtract_store_datapath

bind subtract_store_datapath subtract_store_monitor mon_u (.clk, .sys_rst,
  .issue_valid, .issue_insn, .issue_ready, .exec_done, .store_a, .store_b,
  .lock_req_o, .lock_req_oe);
